/* hdl/ssq_pkg.sv */
package ssq_pkg;

   // clock and timing figures, times in ns
   localparam int CLK_MHZ               = 125;
   localparam int CLK_HZ                = 125_000_000;
   localparam int INIT_DELAY_NS         = 1_400_000;
   localparam int BOOT_HOLD_NS          = 85_000;
   localparam int CODE_VALID_NS         = 500;
   localparam int GOOD_DELAY_A_NS       = 440_000;
   localparam int GOOD_DELAY_B_NS       = 1_500_000;
   localparam int ALT_INITIAL_DELAY_NS  = 1_000_000;
   localparam int OC_WAIT_NS            = 12_000_000;
   localparam int STEP_FREQ_HZ          = 330_000;

   // least times round up to whole cycles
   localparam int INIT_DELAY_CYC   = (INIT_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int BOOT_HOLD_CYC    = (BOOT_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int CODE_VALID_CYC   = (CODE_VALID_NS * CLK_MHZ + 999) / 1000;
   localparam int GOOD_DELAY_A_CYC = (GOOD_DELAY_A_NS * CLK_MHZ + 999) / 1000;
   localparam int GOOD_DELAY_B_CYC = (GOOD_DELAY_B_NS * CLK_MHZ + 999) / 1000;
   localparam int ALT_INIT_CYC     =
      (ALT_INITIAL_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int OC_WAIT_CYC      = (OC_WAIT_NS * CLK_MHZ + 999) / 1000;
   // step interval, rounded down so the rate is never slower
   localparam logic [15:0] STEP_DEFAULT_CYC = 16'(CLK_HZ / STEP_FREQ_HZ);

   // reference in 6.25mV steps; boot level 1.1V
   localparam logic [8:0] BOOT_LEVEL_STEPS = 9'h0b0;

   // register word indices, matched against address bits 5:2
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STEP   = 4'h1;
   localparam logic [3:0] REG_STATUS = 4'h2;
   localparam logic [3:0] REG_REF    = 4'h3;

   // control fields and reset values
   localparam int          CTRL_MODE_LSB   = 0;
   localparam int          CTRL_MULTI_BIT  = 2;
   localparam logic [1:0]  CTRL_MODE_RST   = 2'h0;
   localparam logic        CTRL_MULTI_RST  = 1'b1;

   // status fields, and the target field of the reference word
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_GOOD_BIT  = 4;
   localparam int STAT_DRIVE_BIT = 5;
   localparam int STAT_TRI_BIT   = 6;
   localparam int STAT_QUAL_BIT  = 7;
   localparam int STAT_CODE_LSB  = 8;
   localparam int STAT_PIN_BIT   = 16;
   localparam int REF_TARGET_LSB = 16;

   // voltage-code table modes
   typedef enum logic [1:0] {
      MODE_TEN    = 2'b00,
      MODE_ELEVEN = 2'b01,
      MODE_FIVE   = 2'b10,
      MODE_SIX    = 2'b11
   } ssq_mode_e;

   typedef enum logic [3:0] {
      ST_SHUTDOWN    = 4'b0000,
      ST_INIT_DELAY  = 4'b0001,
      ST_FIRST_RAMP  = 4'b0010,
      ST_BOOT_HOLD   = 4'b0011,
      ST_SECOND_RAMP = 4'b0100,
      ST_GOOD_DELAY  = 4'b0101,
      ST_RUN         = 4'b0110,
      ST_OC_WAIT     = 4'b0111,
      ST_OV_LATCH    = 4'b1000
   } ssq_state_e;

endpackage : ssq_pkg

/* hdl/ssq_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module ssq_sequencer #(
   parameter int INIT_DELAY_CYC   = ssq_pkg::INIT_DELAY_CYC,
   parameter int BOOT_HOLD_CYC    = ssq_pkg::BOOT_HOLD_CYC,
   parameter int GOOD_DELAY_A_CYC = ssq_pkg::GOOD_DELAY_A_CYC,
   parameter int GOOD_DELAY_B_CYC = ssq_pkg::GOOD_DELAY_B_CYC,
   parameter int ALT_INIT_CYC     = ssq_pkg::ALT_INIT_CYC,
   parameter int OC_WAIT_CYC      = ssq_pkg::OC_WAIT_CYC
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_b_i,
   // avalon-mm slave
   input  wire logic [5:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   // comparator flags and code pins, all asynchronous
   input  wire logic        bias_por_ok_i,
   input  wire logic        main_enable_ok_i,
   input  wire logic        fourth_phase_enable_ok_i,
   input  wire logic        driver_supply_one_ok_i,
   input  wire logic        driver_supply_two_ok_i,
   input  wire logic        driver_supply_three_ok_i,
   input  wire logic        feedback_pin_above_ref_i,
   input  wire logic        undervoltage_i,
   input  wire logic        overvoltage_i,
   input  wire logic        overcurrent_i,
   input  wire logic        rate_pin_grounded_i,
   input  wire logic [7:0]  voltage_code_i,
   // open-drain power good pin
   input  wire logic        power_good_out_i,
   output logic             power_good_out_o,
   output logic             power_good_out_oe_o,
   // regulator controls
   output logic      [8:0]  reference_code_o,
   output logic             drive_enable_o,
   output logic             phase_tristate_o
);

   localparam int TW = 21;

   logic [19:0]          sync_q;
   logic                 bias_s;
   logic                 en_s;
   logic                 ph4_s;
   logic                 drv1_s;
   logic                 drv2_s;
   logic                 drv3_s;
   logic                 fb_above_s;
   logic                 uv_s;
   logic                 ov_s;
   logic                 oc_s;
   logic                 rate_gnd_s;
   logic                 pin_s;
   logic [7:0]           code_s;
   ssq_pkg::ssq_state_e  state_ff;
   ssq_pkg::ssq_state_e  nxt_state;
   logic [1:0]           mode_ff;
   logic                 multi_ff;
   logic [15:0]          step_div_ff;
   logic [TW-1:0]        timer_ff;
   logic [15:0]          step_cnt_ff;
   logic [7:0]           code_prev_ff;
   logic [6:0]           stable_cnt_ff;
   logic [7:0]           code_smp_ff;
   logic [8:0]           target_ff;
   logic                 drive_on_ff;
   logic                 wait_ff;
   logic                 boot_ramps;
   logic                 qualified;
   logic                 no_load;
   logic                 no_cpu;
   logic                 code_ok;
   logic                 step_tick;
   logic                 timer_done;
   logic                 soft_start;
   logic [8:0]           code_steps;
   logic [15:0]          step_len;
   logic [3:0]           word_sel;
   logic [31:0]          bytemask;

   // every comparator and code pin passes two flops first
   ssq_sync #(
      .WIDTH (20)
   ) u_sync (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .async_i    ({power_good_out_i, rate_pin_grounded_i, overcurrent_i,
                    overvoltage_i, undervoltage_i, feedback_pin_above_ref_i,
                    driver_supply_three_ok_i, driver_supply_two_ok_i,
                    driver_supply_one_ok_i, fourth_phase_enable_ok_i,
                    main_enable_ok_i, bias_por_ok_i, voltage_code_i}),
      .sync_o     (sync_q)
   );

   assign {pin_s, rate_gnd_s, oc_s, ov_s, uv_s, fb_above_s, drv3_s, drv2_s,
           drv1_s, ph4_s, en_s, bias_s, code_s} = sync_q;

   // qualification to leave or stay out of shutdown
   assign qualified = bias_s && en_s
                      && ph4_s
                      && drv1_s && (!multi_ff || (drv2_s && drv3_s));

   assign boot_ramps = (mode_ff == ssq_pkg::MODE_TEN) ||
                       (mode_ff == ssq_pkg::MODE_ELEVEN);

   // code decode per table; linear step mapping
   always_comb
   begin
      case (mode_ff)
         ssq_pkg::MODE_FIVE:
         begin
            code_steps = {4'h0, code_s[4:0]};
            no_cpu     = (code_s[4:0] == 5'h1f);
         end
         ssq_pkg::MODE_SIX:
         begin
            code_steps = {3'h0, code_s[5:0]};
            no_cpu     = (code_s[5:0] == 6'h3f);
         end
         default:
         begin
            code_steps = {1'b0, code_s};
            no_cpu     = (code_s == 8'hff) || (code_s == 8'h00);
         end
      endcase
   end

   assign no_load = (mode_ff == ssq_pkg::MODE_FIVE) && no_cpu;
   assign code_ok = (stable_cnt_ff == 7'(ssq_pkg::CODE_VALID_CYC)) &&
                    !no_cpu;
   assign timer_done = (timer_ff == '0);
   assign step_tick  = (step_cnt_ff == 16'h0000);
   assign soft_start = (state_ff == ssq_pkg::ST_INIT_DELAY) ||
                       (state_ff == ssq_pkg::ST_FIRST_RAMP) ||
                       (state_ff == ssq_pkg::ST_BOOT_HOLD) ||
                       (state_ff == ssq_pkg::ST_SECOND_RAMP);

   // step interval: programmed, or fixed when pin grounded or five/six
   assign step_len = (boot_ramps && !rate_gnd_s) ? step_div_ff
                     : ssq_pkg::STEP_DEFAULT_CYC;

   // sequencing; qualification loss beats every fault
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ssq_pkg::ST_SHUTDOWN:
            if (qualified && !no_load)
               nxt_state = ssq_pkg::ST_INIT_DELAY;
         ssq_pkg::ST_INIT_DELAY:
            if (timer_done)
               nxt_state = boot_ramps ? ssq_pkg::ST_FIRST_RAMP
                                      : ssq_pkg::ST_SECOND_RAMP;
         ssq_pkg::ST_FIRST_RAMP:
            if (reference_code_o == ssq_pkg::BOOT_LEVEL_STEPS)
               nxt_state = ssq_pkg::ST_BOOT_HOLD;
         ssq_pkg::ST_BOOT_HOLD:
            if (timer_done && code_ok)
               nxt_state = ssq_pkg::ST_SECOND_RAMP;
         ssq_pkg::ST_SECOND_RAMP:
            if (reference_code_o == target_ff)
               nxt_state = ssq_pkg::ST_GOOD_DELAY;
         ssq_pkg::ST_GOOD_DELAY:
            if (timer_done)
               nxt_state = ssq_pkg::ST_RUN;
         ssq_pkg::ST_RUN:
            nxt_state = ssq_pkg::ST_RUN;
         ssq_pkg::ST_OC_WAIT:
            if (timer_done)
               nxt_state = ssq_pkg::ST_INIT_DELAY;
         ssq_pkg::ST_OV_LATCH:
            nxt_state = ssq_pkg::ST_OV_LATCH;
         default:
            nxt_state = ssq_pkg::ST_SHUTDOWN;
      endcase
      if (state_ff != ssq_pkg::ST_SHUTDOWN)
      begin
         if (oc_s && state_ff != ssq_pkg::ST_OV_LATCH &&
             state_ff != ssq_pkg::ST_OC_WAIT)
            nxt_state = ssq_pkg::ST_OC_WAIT;
         if (ov_s)
            nxt_state = ssq_pkg::ST_OV_LATCH;
         if (no_cpu && (state_ff == ssq_pkg::ST_RUN ||
                        state_ff == ssq_pkg::ST_GOOD_DELAY))
            nxt_state = ssq_pkg::ST_SHUTDOWN;
         if (!qualified)
            nxt_state = ssq_pkg::ST_SHUTDOWN;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         state_ff <= ssq_pkg::ST_SHUTDOWN;
      else
         state_ff <= nxt_state;
   end

   // one down-counter, loaded on entry to each timed state
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         timer_ff <= '0;
      else if (nxt_state != state_ff)
      begin
         case (nxt_state)
            ssq_pkg::ST_INIT_DELAY:
               timer_ff <= boot_ramps ? TW'(INIT_DELAY_CYC - 1)
                                      : TW'(ALT_INIT_CYC - 1);
            ssq_pkg::ST_BOOT_HOLD:
               timer_ff <= TW'(BOOT_HOLD_CYC - 1);
            ssq_pkg::ST_GOOD_DELAY:
               timer_ff <= boot_ramps ? TW'(GOOD_DELAY_A_CYC - 1)
                                      : TW'(GOOD_DELAY_B_CYC - 1);
            ssq_pkg::ST_OC_WAIT:
               timer_ff <= TW'(OC_WAIT_CYC - 1);
            default:
               timer_ff <= '0;
         endcase
      end
      else if (!timer_done)
         timer_ff <= timer_ff - 1'b1;
   end

   // code must sit still this long before it counts as valid
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         code_prev_ff  <= 8'h00;
         stable_cnt_ff <= 7'h00;
      end
      else
      begin
         code_prev_ff <= code_s;
         if (code_s != code_prev_ff)
            stable_cnt_ff <= 7'h00;
         else if (stable_cnt_ff != 7'(ssq_pkg::CODE_VALID_CYC))
            stable_cnt_ff <= stable_cnt_ff + 7'h01;
      end
   end

   // target sampled at start (five/six) or end of boot hold
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         target_ff   <= 9'h000;
         code_smp_ff <= 8'h00;
      end
      else if ((state_ff == ssq_pkg::ST_SHUTDOWN ||
                state_ff == ssq_pkg::ST_OC_WAIT) &&
               nxt_state == ssq_pkg::ST_INIT_DELAY && !boot_ramps)
      begin
         target_ff   <= code_steps;
         code_smp_ff <= code_s;
      end
      else if (state_ff == ssq_pkg::ST_BOOT_HOLD &&
               nxt_state == ssq_pkg::ST_SECOND_RAMP)
      begin
         target_ff   <= code_steps;
         code_smp_ff <= code_s;
      end
   end

   // step pacing; restarts on every state change
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         step_cnt_ff <= ssq_pkg::STEP_DEFAULT_CYC;
      else if (nxt_state != state_ff || step_tick)
         step_cnt_ff <= step_len - 16'h0001;
      else
         step_cnt_ff <= step_cnt_ff - 16'h0001;
   end

   // reference moves one 6.25mV step per tick, either direction
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         reference_code_o <= 9'h000;
      else if (nxt_state == ssq_pkg::ST_SHUTDOWN ||
               nxt_state == ssq_pkg::ST_OC_WAIT ||
               nxt_state == ssq_pkg::ST_INIT_DELAY)
         reference_code_o <= 9'h000;
      else if (step_tick && state_ff == ssq_pkg::ST_FIRST_RAMP &&
               reference_code_o != ssq_pkg::BOOT_LEVEL_STEPS)
         reference_code_o <= reference_code_o + 9'h001;
      else if (step_tick && state_ff == ssq_pkg::ST_SECOND_RAMP &&
               nxt_state == ssq_pkg::ST_SECOND_RAMP)
      begin
         if (reference_code_o < target_ff)
            reference_code_o <= reference_code_o + 9'h001;
         else if (reference_code_o > target_ff)
            reference_code_o <= reference_code_o - 9'h001;
      end
   end

   // drives: tri-state in shutdown, held off in soft start until output first falls below ref
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         drive_on_ff <= 1'b0;
      else if (nxt_state == ssq_pkg::ST_SHUTDOWN ||
               nxt_state == ssq_pkg::ST_OC_WAIT ||
               nxt_state == ssq_pkg::ST_OV_LATCH ||
               nxt_state == ssq_pkg::ST_INIT_DELAY)
         drive_on_ff <= 1'b0;
      else if (soft_start && !fb_above_s)
         drive_on_ff <= 1'b1;
      else if (nxt_state == ssq_pkg::ST_GOOD_DELAY)
         drive_on_ff <= 1'b1;
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         drive_enable_o   <= 1'b0;
         phase_tristate_o <= 1'b1;
      end
      else
      begin
         drive_enable_o   <= drive_on_ff;
         phase_tristate_o <= (state_ff == ssq_pkg::ST_SHUTDOWN);
      end
   end

   // open drain: pull low unless running clean; released means high
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         power_good_out_o    <= 1'b0;
         power_good_out_oe_o <= 1'b1;
      end
      else
      begin
         power_good_out_o    <= 1'b0;
         power_good_out_oe_o <= !(state_ff == ssq_pkg::ST_RUN
                                  && !uv_s
                                  && !ov_s && !oc_s && !no_cpu);
      end
   end

   // bus slave: one wait cycle, answer on the second request cycle
   assign word_sel = avs_address_i[5:2];
   assign bytemask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         wait_ff <= 1'b1;
      else if ((avs_read_i || avs_write_i) && wait_ff)
         wait_ff <= 1'b0;
      else
         wait_ff <= 1'b1;
   end

   assign avs_waitrequest_o = wait_ff;

   // writes land on the edge where waitrequest is seen low
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         mode_ff     <= ssq_pkg::CTRL_MODE_RST;
         multi_ff    <= ssq_pkg::CTRL_MULTI_RST;
         step_div_ff <= ssq_pkg::STEP_DEFAULT_CYC;
      end
      else if (avs_write_i && !wait_ff)
      begin
         if (word_sel == ssq_pkg::REG_CTRL && avs_byteenable_i[0])
         begin
            mode_ff  <= avs_writedata_i[ssq_pkg::CTRL_MODE_LSB +: 2];
            multi_ff <= avs_writedata_i[ssq_pkg::CTRL_MULTI_BIT];
         end
         if (word_sel == ssq_pkg::REG_STEP)
            step_div_ff <= (step_div_ff & ~bytemask[15:0]) |
                           (avs_writedata_i[15:0] & bytemask[15:0]);
      end
   end

   // read data captured with the wait drop, held through the answer
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         avs_readdata_o <= 32'h0000_0000;
      else if (avs_read_i && wait_ff)
      begin
         avs_readdata_o <= 32'h0000_0000;
         case (word_sel)
            ssq_pkg::REG_CTRL:
            begin
               avs_readdata_o[ssq_pkg::CTRL_MODE_LSB +: 2] <= mode_ff;
               avs_readdata_o[ssq_pkg::CTRL_MULTI_BIT]     <= multi_ff;
            end
            ssq_pkg::REG_STEP:
               avs_readdata_o[15:0] <= step_div_ff;
            ssq_pkg::REG_STATUS:
            begin
               avs_readdata_o[ssq_pkg::STAT_STATE_LSB +: 4] <= state_ff;
               avs_readdata_o[ssq_pkg::STAT_GOOD_BIT]  <= !power_good_out_oe_o;
               avs_readdata_o[ssq_pkg::STAT_DRIVE_BIT] <= drive_enable_o;
               avs_readdata_o[ssq_pkg::STAT_TRI_BIT]   <= phase_tristate_o;
               avs_readdata_o[ssq_pkg::STAT_QUAL_BIT]  <= qualified;
               avs_readdata_o[ssq_pkg::STAT_CODE_LSB +: 8] <= code_smp_ff;
               avs_readdata_o[ssq_pkg::STAT_PIN_BIT]   <= pin_s;
            end
            ssq_pkg::REG_REF:
            begin
               avs_readdata_o[8:0] <= reference_code_o;
               avs_readdata_o[ssq_pkg::REF_TARGET_LSB +: 9] <= target_ff;
            end
            default:
               avs_readdata_o <= 32'h0000_0000;
         endcase
      end
   end

endmodule : ssq_sequencer
`default_nettype wire

/* hdl/ssq_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module ssq_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk_i,
   input  wire logic             rst_b_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_ff;

   // two stages; only the second stage is read outside
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         meta_ff <= '0;
         sync_o  <= '0;
      end
      else
      begin
         meta_ff <= async_i;
         sync_o  <= meta_ff;
      end
   end

endmodule : ssq_sync
`default_nettype wire

/* sim/ssq_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module ssq_chk (
   input wire logic       core_clk_i,
   input wire logic       rst_b_i,
   input wire logic       avs_read_i,
   input wire logic       avs_write_i,
   input wire logic       avs_waitrequest_o,
   input wire logic       main_enable_ok_i,
   input wire logic       undervoltage_i,
   input wire logic       overvoltage_i,
   input wire logic       overcurrent_i,
   input wire logic       power_good_out_o,
   input wire logic       power_good_out_oe_o,
   input wire logic [8:0] reference_code_o,
   input wire logic       drive_enable_o,
   input wire logic       phase_tristate_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   // six cycles cover the two-flop sync plus the registered outputs
   a_enable_loss_off: assert property (
      !main_enable_ok_i [*6] |-> phase_tristate_o && !drive_enable_o
      && reference_code_o == 9'h000 && power_good_out_oe_o)
      else $error("enable loss did not shut down");
   a_fault_pg_low: assert property (
      (undervoltage_i || overvoltage_i || overcurrent_i) [*6]
      |-> power_good_out_oe_o) else $error("fault left power good high");
   a_latch_drive_off: assert property (
      (overvoltage_i || overcurrent_i) [*6] |-> !drive_enable_o)
      else $error("drives on during fault");
   a_good_needs_run: assert property (
      !power_good_out_oe_o |-> drive_enable_o && !phase_tristate_o)
      else $error("power good released while not regulating");
   a_tri_no_drive: assert property (
      phase_tristate_o |-> !drive_enable_o && power_good_out_oe_o)
      else $error("drive or power good while high impedance");
   a_od_never_high: assert property (
      power_good_out_o == 1'b0) else $error("open drain driven high");
   // the clear to zero on shutdown or overcurrent lands while drives still show on
   a_ref_one_step: assert property (
      drive_enable_o && $past(drive_enable_o)
      && reference_code_o != $past(reference_code_o)
      && reference_code_o != 9'h000
      |-> reference_code_o == $past(reference_code_o) + 9'h001
      || $past(reference_code_o) == reference_code_o + 9'h001)
      else $error("reference moved more than one step");
   a_bus_one_wait: assert property (
      (avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("bus answer not after one wait cycle");
endmodule : ssq_chk
bind ssq_sequencer ssq_chk ssq_chk_i (
   .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
   .main_enable_ok_i(main_enable_ok_i), .undervoltage_i(undervoltage_i),
   .overvoltage_i(overvoltage_i), .overcurrent_i(overcurrent_i),
   .power_good_out_o(power_good_out_o),
   .power_good_out_oe_o(power_good_out_oe_o),
   .reference_code_o(reference_code_o), .drive_enable_o(drive_enable_o),
   .phase_tristate_o(phase_tristate_o));
`default_nettype wire

/* sim/ssq_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ssq_host_model (
   input  wire logic       core_clk_i,
   input  wire logic [7:0] code_req_i,
   input  wire logic       pg_oe_i,
   input  wire logic       pg_drv_i,
   output logic      [7:0] voltage_code_o,
   output logic            pg_pin_o
);
   // code pins move just after an edge, as a processor output would
   initial voltage_code_o = 8'h00;
   always @(posedge core_clk_i) voltage_code_o <= code_req_i;
   // released open-drain line is lifted by the monitor's pull-up
   assign pg_pin_o = pg_oe_i ? pg_drv_i : 1'b1;
endmodule : ssq_host_model
`default_nettype wire

/* sim/ssq_sequencer_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module ssq_sequencer_tb;
   logic        clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, en = 1'b0;
   logic        fb = 1'b0, wreq, pg_o, pg_oe, drv, tri_o, pin;
   logic [4:0]  qual = 5'h00; // bias, fourth phase, supplies one to three
   logic [3:0]  be = 4'hf;
   logic        rg = 1'b0;    // rate pin grounded
   logic [2:0]  flt = 3'h0;  // under, over, overcurrent
   logic [5:0]  addr = 6'h00;
   logic [7:0]  code = 8'h00, vcode;
   logic [8:0]  ref_code;
   logic [31:0] wdata = 32'h0, rdata, q;
   logic [4:0]  masks [5] = '{5'h0f, 5'h17, 5'h1b, 5'h1d, 5'h1e};
   int          error_cnt = 0, n_compared = 0, cyc = 0;
   // ctrl, code pins, expected target reference
   logic [19:0] rows [4] = '{{3'h0, 8'hc0, 9'h0c0}, {3'h1, 8'ha0, 9'h0a0},
                             {3'h2, 8'he2, 9'h002}, {3'h3, 8'h43, 9'h003}};
   always #4 clk = ~clk;
   // short delays keep the run small; step interval is set over the bus
   localparam int SHORT_CYC = 20;
   ssq_sequencer #(.INIT_DELAY_CYC(50), .BOOT_HOLD_CYC(SHORT_CYC),
      .GOOD_DELAY_A_CYC(SHORT_CYC), .GOOD_DELAY_B_CYC(SHORT_CYC),
      .ALT_INIT_CYC(SHORT_CYC), .OC_WAIT_CYC(30)) ssq_sequencer_i (
      .core_clk_i(clk), .rst_b_i(rst_b), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(be), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .bias_por_ok_i(qual[4]),
      .main_enable_ok_i(en), .fourth_phase_enable_ok_i(qual[3]),
      .driver_supply_one_ok_i(qual[2]), .driver_supply_two_ok_i(qual[1]),
      .driver_supply_three_ok_i(qual[0]), .feedback_pin_above_ref_i(fb),
      .undervoltage_i(flt[2]), .overvoltage_i(flt[1]),
      .overcurrent_i(flt[0]), .rate_pin_grounded_i(rg),
      .voltage_code_i(vcode), .power_good_out_i(pin),
      .power_good_out_o(pg_o), .power_good_out_oe_o(pg_oe),
      .reference_code_o(ref_code), .drive_enable_o(drv),
      .phase_tristate_o(tri_o));
   ssq_host_model ssq_host_model_i (.core_clk_i(clk), .code_req_i(code),
      .pg_oe_i(pg_oe), .pg_drv_i(pg_o), .voltage_code_o(vcode),
      .pg_pin_o(pin));
   task automatic stop_test();
      if (error_cnt == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk
   // held until waitrequest is sampled low; the slave sets the pace
   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= ~w;
      wdata <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wreq !== 1'b0 && n < 20);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      chk(wreq, 1'b0, "waitrequest");
   endtask : bus
   task automatic wait_pg(input logic v);
      int n;
      n = 0;
      while (pg_oe !== v && n < 4000)
      begin
         @(posedge clk);
         n++;
      end
      chk(pg_oe, v, "pg_oe");
   endtask : wait_pg
   // enable off long enough to reach shutdown, reprogram, enable again
   task automatic restart(input logic [2:0] ctrl, input logic [7:0] c);
      en <= 1'b0;
      code <= c;
      repeat (8) @(posedge clk);
      chk({ref_code, tri_o}, 10'h001, "shutdown");
      bus(1'b1, 6'h00, {29'h0, ctrl});
      bus(1'b1, 6'h04, 32'h2);
      en <= 1'b1;
   endtask : restart
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 60000)
      begin
         error_cnt++;
         stop_test();
      end
   end
   initial
   begin
      repeat (15) @(posedge clk);
      chk({wreq, pg_oe, tri_o, ref_code}, 12'he00, "reset");
      @(posedge clk);
      rst_b <= 1'b1;
      qual <= 5'h1f;
      foreach (rows[i])
      begin
         restart(rows[i][19:17], rows[i][16:9]);
         wait_pg(1'b0);
         chk(ref_code, rows[i][8:0], "target");
         bus(1'b0, 6'h08, 32'h0);
         chk({q[16], q[4:0]}, 6'h36, "status");
      end
      flt <= 3'b100;
      repeat (8) @(posedge clk);
      chk(pg_oe, 1'b1, "uv");
      flt <= 3'b000;
      repeat (8) @(posedge clk);
      chk(pg_oe, 1'b0, "uv back");
      flt <= 3'b001;
      repeat (8) @(posedge clk);
      chk({pg_oe, drv}, 2'b10, "oc");
      flt <= 3'b000;
      bus(1'b0, 6'h08, 32'h0);
      chk(q[3:0], 4'h7, "oc wait");
      wait_pg(1'b0);
      flt <= 3'b010;
      repeat (8) @(posedge clk);
      chk(pg_oe, 1'b1, "ov");
      flt <= 3'b000;
      repeat (200) @(posedge clk);
      bus(1'b0, 6'h08, 32'h0);
      chk(q[4:0], 5'h08, "ov latch");
      restart(3'h3, 8'h03);
      wait_pg(1'b0);
      restart(3'h2, 8'h1f);
      repeat (200) @(posedge clk);
      chk(tri_o, 1'b1, "no load");
      foreach (masks[i])
      begin
         qual <= masks[i];
         restart(3'h4, 8'hb0);
         repeat (100) @(posedge clk);
         chk(tri_o, 1'b1, "qualify");
      end
      fb <= 1'b1;
      restart(3'h0, 8'hb0);
      repeat (300) @(posedge clk);
      chk({tri_o, drv}, 2'b00, "precharge");
      wait_pg(1'b0);
      chk(drv, 1'b1, "precharge on");
      bus(1'b1, 6'h0c, 32'hffffffff);
      bus(1'b0, 6'h0c, 32'h0);
      chk(q[8:0], 9'h0b0, "ref ro");
      bus(1'b0, 6'h20, 32'h0);
      chk(q, 32'h0, "unmapped");
      be <= 4'he;
      bus(1'b1, 6'h00, 32'h1);
      be <= 4'hf;
      bus(1'b0, 6'h00, 32'h0);
      chk(q[2:0], 3'h0, "ctrl lane");
      code <= 8'hff;
      repeat (8) @(posedge clk);
      chk(pg_oe, 1'b1, "no cpu");
      rg <= 1'b1;
      restart(3'h0, 8'hb0);
      repeat (500) @(posedge clk);
      chk(ref_code, 9'h001, "rate pin");
      stop_test();
   end
endmodule : ssq_sequencer_tb
`default_nettype wire
